//--- verilog/cctmr_consts.svh
// offsets, field positions, reset values and clock ratios of the capture timer
`ifndef CCTMR_CONSTS_SVH
`define CCTMR_CONSTS_SVH
`define CCTMR_CTRL_ADDR 8'hc8
`define CCTMR_CTRL_RESET 8'h00
`define CCTMR_BIT_HIGH_FLAG 7
`define CCTMR_BIT_LOW_FLAG 6
`define CCTMR_BIT_LOW_IRQ_EN 5
`define CCTMR_BIT_CAPTURE_EN 4
`define CCTMR_BIT_SPLIT 3
`define CCTMR_BIT_RUN 2
`define CCTMR_BIT_UNUSED 1
`define CCTMR_BIT_EXT_CLK 0
`define CCTMR_CTRL_WMASK 8'hfd
`define CCTMR_SYS_DIV 12
`define CCTMR_EXT_DIV 8
`define CCTMR_CLK_PERIOD_NS 20
`endif

//--- verilog/cctmr_pkg.sv
// types shared by the capture timer files
package cctmr_pkg;
    typedef enum logic {
        CCTMR_MODE_WIDE,
        CCTMR_MODE_SPLIT
    } cctmr_mode_t;
    typedef enum logic [1:0] {
        CCTMR_SRC_IDLE,
        CCTMR_SRC_SYS,
        CCTMR_SRC_EXT
    } cctmr_src_t;
endpackage : cctmr_pkg

//--- verilog/cctmr_tick_gen.sv
// prescaled count ticks: system clock divided by 12 or external clock divided by 8
`timescale 1ns/10ps
`include "cctmr_consts.svh"
module cctmr_tick_gen #(
    parameter int SYS_DIV = `CCTMR_SYS_DIV,
    parameter int EXT_DIV = `CCTMR_EXT_DIV
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // external clock level, already synchronous
    input wire logic extClk,
    // one-cycle tick outputs
    output logic sysDivTick,
    output logic extDivTick
);
    logic [3:0] sysCnt_q;
    logic [2:0] extCnt_q;
    logic extPrev_q;
    logic extRise;

    assign extRise = extClk & ~extPrev_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sysCnt_q <= 4'h0;
            sysDivTick <= 1'b0;
        end else if (sysCnt_q == 4'(SYS_DIV - 1)) begin
            sysCnt_q <= 4'h0;
            sysDivTick <= 1'b1;
        end else begin
            sysCnt_q <= sysCnt_q + 4'h1;
            sysDivTick <= 1'b0;
        end
    end

    // external edges are counted in the system domain, so the result is synchronous
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            extPrev_q <= 1'b0;
            extCnt_q <= 3'h0;
            extDivTick <= 1'b0;
        end else begin
            extPrev_q <= extClk;
            extDivTick <= 1'b0;
            if (extRise) begin
                if (extCnt_q == 3'(EXT_DIV - 1)) begin
                    extCnt_q <= 3'h0;
                    extDivTick <= 1'b1;
                end else begin
                    extCnt_q <= extCnt_q + 3'h1;
                end
            end
        end
    end
endmodule : cctmr_tick_gen

//--- verilog/cctmr_edge_det.sv
// rising-edge detector for the comparator output
`timescale 1ns/10ps
module cctmr_edge_det (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // level in, pulse out
    input wire logic level,
    output logic rise
);
    logic prev_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end

    // combinational so every edge reaches the capture logic in its own cycle
    assign rise = level & ~prev_q;
endmodule : cctmr_edge_det

//--- verilog/cctmr_timer.sv
// timer two: 16-bit or split 8-bit auto-reload timer with comparator capture
`timescale 1ns/10ps
`include "cctmr_consts.svh"
module cctmr_timer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // special function register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    // counter and reload bytes, written by software
    input wire logic countLowWrite,
    input wire logic countHighWrite,
    input wire logic reloadLowWrite,
    input wire logic reloadHighWrite,
    input wire logic [7:0] byteWdata,
    output logic [7:0] countLowByte,
    output logic [7:0] countHighByte,
    output logic [7:0] reloadLowByte,
    output logic [7:0] reloadHighByte,
    // clock selects held in the clock control register
    input wire logic highByteClockSelect,
    input wire logic lowByteClockSelect,
    // external clock and comparator output, synchronous levels
    input wire logic extClk,
    input wire logic comparatorOut,
    // interrupt side
    input wire logic timerIrqEnable,
    output logic timerIrq
);
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic sysDivTick;
    logic extDivTick;
    logic cmpRise;
    logic captureMode;
    logic captureEvent;
    logic selTick;
    logic lowTick;
    logic highTick;
    logic lowWrap;
    logic highWrap;
    logic ctrlWrite;
    cctmr_pkg::cctmr_mode_t mode;
    cctmr_pkg::cctmr_src_t lowSrc;
    cctmr_pkg::cctmr_src_t highSrc;

    cctmr_tick_gen u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .extClk(extClk),
        .sysDivTick(sysDivTick),
        .extDivTick(extDivTick)
    );

    cctmr_edge_det u_cmp (
        .ref_clk(ref_clk),
        .rst(rst),
        .level(comparatorOut),
        .rise(cmpRise)
    );

    assign ctrlWrite = sfrWrite && (sfrAddr == `CCTMR_CTRL_ADDR);
    assign mode = ctrl_q[`CCTMR_BIT_SPLIT] ? cctmr_pkg::CCTMR_MODE_SPLIT
                                           : cctmr_pkg::CCTMR_MODE_WIDE;
    assign captureMode = ctrl_q[`CCTMR_BIT_CAPTURE_EN]
                         && (mode == cctmr_pkg::CCTMR_MODE_WIDE);
    assign captureEvent = captureMode && cmpRise;

    // prescaled source picked by the external select bit
    assign selTick = ctrl_q[`CCTMR_BIT_EXT_CLK] ? extDivTick : sysDivTick;

    // per-byte source: the clock control selects override to the raw system clock
    always_comb begin
        lowSrc = ctrl_q[`CCTMR_BIT_EXT_CLK] ? cctmr_pkg::CCTMR_SRC_EXT
                                            : cctmr_pkg::CCTMR_SRC_IDLE;
        highSrc = lowSrc;
        if (lowByteClockSelect) begin
            lowSrc = cctmr_pkg::CCTMR_SRC_SYS;
        end
        if (highByteClockSelect) begin
            highSrc = cctmr_pkg::CCTMR_SRC_SYS;
        end
    end

    function automatic logic srcTick(input cctmr_pkg::cctmr_src_t src, input logic pre);
        case (src)
            cctmr_pkg::CCTMR_SRC_SYS: srcTick = 1'b1;
            cctmr_pkg::CCTMR_SRC_EXT: srcTick = pre;
            cctmr_pkg::CCTMR_SRC_IDLE: srcTick = pre;
            default: srcTick = 1'b0;
        endcase
    endfunction : srcTick

    // wide mode follows the low-byte select for the whole 16-bit count
    always_comb begin
        case (mode)
            cctmr_pkg::CCTMR_MODE_SPLIT: begin
                lowTick = srcTick(lowSrc, selTick);
                highTick = ctrl_q[`CCTMR_BIT_RUN] && srcTick(highSrc, selTick);
            end
            cctmr_pkg::CCTMR_MODE_WIDE: begin
                lowTick = ctrl_q[`CCTMR_BIT_RUN] && srcTick(lowSrc, selTick);
                highTick = lowTick && (countLowByte == 8'hff);
            end
            default: begin
                lowTick = 1'b0;
                highTick = 1'b0;
            end
        endcase
    end

    assign lowWrap = lowTick && (countLowByte == 8'hff);
    assign highWrap = highTick && (countHighByte == 8'hff);

    // counter bytes; reload on wrap, except in capture mode where they run free
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            countLowByte <= 8'h00;
        end else if (countLowWrite) begin
            countLowByte <= byteWdata;
        end else if (lowTick) begin
            if (lowWrap && (mode == cctmr_pkg::CCTMR_MODE_SPLIT)) begin
                countLowByte <= reloadLowByte;
            end else if (lowWrap && !captureMode && !highWrap) begin
                countLowByte <= 8'h00;
            end else if (highWrap && !captureMode) begin
                countLowByte <= reloadLowByte;
            end else begin
                countLowByte <= countLowByte + 8'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            countHighByte <= 8'h00;
        end else if (countHighWrite) begin
            countHighByte <= byteWdata;
        end else if (highTick) begin
            if (highWrap && !captureMode) begin
                countHighByte <= reloadHighByte;
            end else begin
                countHighByte <= countHighByte + 8'h01;
            end
        end
    end

    // capture overrides a software write to the reload bytes in the same cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reloadLowByte <= 8'h00;
            reloadHighByte <= 8'h00;
        end else if (captureEvent) begin
            reloadLowByte <= countLowByte;
            reloadHighByte <= countHighByte;
        end else begin
            if (reloadLowWrite) begin
                reloadLowByte <= byteWdata;
            end
            if (reloadHighWrite) begin
                reloadHighByte <= byteWdata;
            end
        end
    end

    // control register; hardware flag sets win over a software clear
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrlWrite) begin
            ctrl_d = sfrWdata & `CCTMR_CTRL_WMASK;
        end
        if (highWrap || captureEvent) begin
            ctrl_d[`CCTMR_BIT_HIGH_FLAG] = 1'b1;
        end
        if (lowWrap) begin
            ctrl_d[`CCTMR_BIT_LOW_FLAG] = 1'b1;
        end
        ctrl_d[`CCTMR_BIT_UNUSED] = 1'b0;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= `CCTMR_CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_comb begin
        if (sfrAddr == `CCTMR_CTRL_ADDR) begin
            sfrRdata = ctrl_q;
        end else begin
            sfrRdata = 8'h00;
        end
    end

    // level request from the sticky flags; flags stay until software clears them
    assign timerIrq = timerIrqEnable && (ctrl_q[`CCTMR_BIT_HIGH_FLAG]
        || (ctrl_q[`CCTMR_BIT_LOW_FLAG] && ctrl_q[`CCTMR_BIT_LOW_IRQ_EN]));
endmodule : cctmr_timer

//--- tb/cctmr_timer_assertions.sv
// concurrent checks on the capture timer ports
`timescale 1ns/10ps
module cctmr_timer_assertions (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    // byte writes and bytes
    input wire logic countLowWrite,
    input wire logic countHighWrite,
    input wire logic reloadLowWrite,
    input wire logic reloadHighWrite,
    input wire logic [7:0] countLowByte,
    input wire logic [7:0] countHighByte,
    input wire logic [7:0] reloadLowByte,
    input wire logic [7:0] reloadHighByte,
    // clock select, comparator, interrupt
    input wire logic lowByteClockSelect,
    input wire logic comparatorOut,
    input wire logic timerIrqEnable,
    input wire logic timerIrq
);
    logic [7:0] ctl_q;
    // mirrors each written byte whole and unmasked; the flags are never read from here
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl_q <= 8'h00;
        end else if (sfrWrite && sfrAddr == 8'hc8) begin
            ctl_q <= sfrWdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence capEvent;
        $rose(comparatorOut) && ctl_q[4] && !ctl_q[3];
    endsequence
    chk_capture_copies: assert property (
        capEvent |=> {reloadHighByte, reloadLowByte} == $past({countHighByte, countLowByte}))
        else $error("capture copy wrong");
    chk_capture_flag: assert property (
        capEvent ##1 sfrAddr == 8'hc8 |-> sfrRdata[7]) else $error("capture flag missing");
    chk_capture_irq: assert property (
        capEvent ##1 timerIrqEnable |-> timerIrq) else $error("capture irq missing");
    chk_irq_gated: assert property (
        !timerIrqEnable |-> !timerIrq) else $error("irq while disabled");
    chk_unused_zero: assert property (
        sfrAddr == 8'hc8 |-> !sfrRdata[1]) else $error("bit 1 not zero");
    chk_no_capture: assert property (
        $rose(comparatorOut) && !(ctl_q[4] && !ctl_q[3]) && !reloadLowWrite && !reloadHighWrite
        |=> $stable({reloadHighByte, reloadLowByte})) else $error("capture outside mode");
    chk_stop_holds: assert property (
        !ctl_q[2] && !ctl_q[3] && !countLowWrite && !countHighWrite
        |=> $stable({countHighByte, countLowByte})) else $error("stopped count moved");
    chk_split_high: assert property (
        ctl_q[3] && !ctl_q[2] && !countHighWrite |=> $stable(countHighByte))
        else $error("split high moved");
    chk_split_low: assert property (
        ctl_q[3] && !ctl_q[2] && lowByteClockSelect && !countLowWrite && reloadLowByte != 8'hff
        |=> countLowByte != $past(countLowByte)) else $error("split low stalled");
endmodule : cctmr_timer_assertions
bind cctmr_timer cctmr_timer_assertions u_cctmr_timer_assertions (
    .ref_clk, .rst, .sfrAddr, .sfrWrite, .sfrWdata, .sfrRdata, .countLowWrite,
    .countHighWrite, .reloadLowWrite, .reloadHighWrite, .countLowByte, .countHighByte,
    .reloadLowByte, .reloadHighByte, .lowByteClockSelect, .comparatorOut, .timerIrqEnable,
    .timerIrq
);

//--- tb/cctmr_comp_model.sv
// comparator output model: one clean high pulse per request
`timescale 1ns/10ps
module cctmr_comp_model (
    // clock
    input wire logic ref_clk,
    // request in, comparator level out
    input wire logic fire,
    output logic comparatorOut
);
    int hold = 0;
    always @(posedge ref_clk) begin
        if (fire) begin
            hold <= 4;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
    end
    // back low between requests so each one is a fresh rising edge
    assign comparatorOut = (hold > 0);
endmodule : cctmr_comp_model

//--- tb/cctmr_timer_bench.sv
// self-checking bench for the capture timer
`timescale 1ns/10ps
module cctmr_timer_bench;
    logic ref_clk, rst, wr, ls, hs, ext, ien, fire, irq, cmp;
    logic [7:0] addr, wd, bw, rd, cl, ch, rl, rh;
    logic [3:0] bs;
    logic [15:0] a;
    int num_errors = 0;
    int n_compared = 0;
    cctmr_timer u_cctmr_timer (.ref_clk, .rst, .sfrAddr(addr), .sfrWrite(wr), .sfrWdata(wd),
        .sfrRdata(rd), .countLowWrite(bs[0]), .countHighWrite(bs[1]), .reloadLowWrite(bs[2]),
        .reloadHighWrite(bs[3]), .byteWdata(bw), .countLowByte(cl), .countHighByte(ch),
        .reloadLowByte(rl), .reloadHighByte(rh), .highByteClockSelect(hs),
        .lowByteClockSelect(ls), .extClk(ext), .comparatorOut(cmp), .timerIrqEnable(ien),
        .timerIrq(irq));
    cctmr_comp_model u_cctmr_comp_model (.ref_clk, .fire, .comparatorOut(cmp));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task cyc(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task chk(logic [15:0] g, logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task wctl(logic [7:0] v);
        wd = v;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask : wctl
    // one strobe bit per byte: count low, count high, reload low, reload high
    task wb(logic [3:0] s, logic [7:0] v);
        bs = s;
        bw = v;
        cyc(1);
        bs = 4'h0;
    endtask : wb
    task waitbit(int b);
        int i;
        for (i = 0; i < 300 && rd[b] !== 1'b1; i++) begin
            cyc(1);
        end
        if (i == 300) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : waitbit
    task pulse;
        fire = 1'b1;
        cyc(1);
        fire = 1'b0;
        cyc(4);
    endtask : pulse
    initial begin
        {wr, ls, hs, ext, ien, fire, bs, wd, bw} = '0;
        addr = 8'hc8;
        rst = 1'b1;
        cyc(16);
        rst = 1'b0;
        chk(16'(rd), 16'h0000);
        wctl(8'hff);
        chk(16'(rd), 16'h00fd);
        addr = 8'h00;
        cyc(1);
        chk(16'(rd), 16'h0000);
        addr = 8'hc8;
        wctl(8'h00);
        $display("test registers done");
        ls = 1'b1;
        wb(4'h8, 8'h34);
        wb(4'h4, 8'h12);
        wb(4'h2, 8'hff);
        wb(4'h1, 8'hfe);
        wctl(8'h04);
        waitbit(7);
        chk(16'(rd[7:6]), 16'h0003);
        wctl(8'h00);
        chk(16'(ch), 16'h0034);
        wb(4'h3, 8'h11);
        cyc(20);
        chk({ch, cl}, 16'h1111);
        $display("test wide done");
        ls = 1'b0;
        wb(4'h3, 8'h00);
        wctl(8'h05);
        repeat (16) begin
            ext = 1'b1;
            cyc(2);
            ext = 1'b0;
            cyc(2);
        end
        wctl(8'h00);
        chk({ch, cl}, 16'h0002);
        wb(4'h3, 8'h00);
        wctl(8'h04);
        cyc(120);
        wctl(8'h00);
        chk(16'(cl >= 8'h09 && cl <= 8'h0b), 16'h0001);
        $display("test clocks done");
        ien = 1'b1;
        ls = 1'b1;
        wb(4'h2, 8'hbe);
        wb(4'h1, 8'hef);
        wctl(8'h10);
        pulse();
        chk({rh, rl}, 16'hbeef);
        chk(16'({rd[7], irq}), 16'h0003);
        wb(4'h3, 8'hca);
        wctl(8'h10);
        pulse();
        chk({rh, rl}, 16'hcaca);
        wctl(8'h14);
        pulse();
        a = {rh, rl};
        pulse();
        chk({rh, rl} - a, 16'h0005);
        $display("test capture done");
        wb(4'hc, 8'h5a);
        wctl(8'h18);
        pulse();
        chk({rh, rl}, 16'h5a5a);
        wb(4'h4, 8'hf0);
        wb(4'h2, 8'h55);
        wb(4'h1, 8'hfd);
        wctl(8'h28);
        waitbit(6);
        chk(16'(irq), 16'h0001);
        chk(16'(ch), 16'h0055);
        chk(16'(cl[7:4]), 16'h000f);
        chk(16'(rd[7:6]), 16'h0001);
        hs = 1'b1;
        wb(4'h2, 8'hfe);
        wctl(8'h0c);
        cyc(4);
        chk(16'(ch), 16'h005c);
        chk(16'(rd[7]), 16'h0001);
        $display("test split done");
        tally_and_finish();
    end
endmodule : cctmr_timer_bench
